// ### rtl/byte_counter.v
// One 8-bit counter with auto-reload on wrap.
// Assumes tick is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module byte_counter #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire reset,
   input wire tick,
   input wire reload_en,
   input wire [WIDTH-1:0] reload_val,
   input wire load,
   input wire [WIDTH-1:0] load_val,
   output reg [WIDTH-1:0] count_ff,
   output wire wrap
);
   reg [WIDTH-1:0] nxt_count;
   assign wrap = tick & (&count_ff);
   always @* begin
      nxt_count = count_ff;
      if (load) begin
         nxt_count = load_val;
      end else if (wrap) begin
         nxt_count = reload_en ? reload_val : {WIDTH{1'b0}}; // R9
      end else if (tick) begin
         nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   always @(posedge clk) begin
      if (reset) begin
         count_ff <= {WIDTH{1'b0}};
      end else begin
         count_ff <= nxt_count;
      end
   end
endmodule // byte_counter
`default_nettype wire

// ### rtl/timer_two.v
// Timer with control register, reload pair and comparator capture.
// Assumes synchronous SFR bus: sfr_wr/sfr_bit_wr strobes, combinational read data.
`timescale 1ns/1ps
`default_nettype none
`include "timer_two_defines.vh"
module timer_two (
   input wire clk,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire sfr_bit_wr,
   input wire [2:0] sfr_bit_sel,
   input wire sfr_bit_val,
   output reg [7:0] sfr_rdata,
   input wire timer_irq_enable,
   input wire tick_high,
   input wire tick_low,
   input wire comparator_out,
   output wire timer_irq,
   output wire split_mode_select,
   output wire external_clock_select
);
   reg [7:0] timer_control_ff;
   wire [7:0] nxt_control;
   reg [7:0] reload_low_byte_ff;
   reg [7:0] reload_high_byte_ff;
   reg comp_prev_ff;
   wire [7:0] count_low_byte;
   wire [7:0] count_high_byte;
   wire low_wrap;
   wire high_wrap_raw;
   wire high_tick;
   wire run;
   wire split;
   wire capture_mode;
   wire capture;
   wire ctrl_sel;
   wire hi_set;
   wire lo_set;
   wire byte_wr_ctrl;
   wire bit_wr_ctrl;
   wire [7:0] hw_set;
   localparam [7:0] CTRL_WMASK = `TMR_CTRL_WMASK;
   assign split = timer_control_ff[`TMR_BIT_SPLIT];
   assign run = timer_control_ff[`TMR_BIT_RUN];
   assign split_mode_select = split;
   assign external_clock_select = timer_control_ff[`TMR_BIT_XCLK];
   assign capture_mode = timer_control_ff[`TMR_BIT_CAPEN] & ~split; // R8
   assign capture = capture_mode & comparator_out & ~comp_prev_ff; // R6
   assign ctrl_sel = (sfr_addr == `TMR_CTRL_ADDR); // R7
   // Low byte always runs in split mode; in 16-bit mode it needs run
   byte_counter #(.WIDTH(8)) u_low (
      .clk(clk),
      .reset(reset),
      .tick(tick_low & (split | run)),
      .reload_en(split),
      .reload_val(reload_low_byte_ff),
      .load(~split & high_wrap_raw & ~capture_mode),
      .load_val(reload_low_byte_ff),
      .count_ff(count_low_byte),
      .wrap(low_wrap)
   );
   // In 16-bit mode the high byte advances on the low byte's carry
   assign high_tick = split ? (tick_high & run) : low_wrap;
   byte_counter #(.WIDTH(8)) u_high (
      .clk(clk),
      .reset(reset),
      .tick(high_tick),
      .reload_en(split | ~capture_mode), // R9
      .reload_val(reload_high_byte_ff),
      .load(1'b0),
      .load_val(8'h00),
      .count_ff(count_high_byte),
      .wrap(high_wrap_raw)
   );
   // Capture mode free-runs without reload so successive captures differ by period
   assign hi_set = high_wrap_raw | capture; // R1 R8
   assign lo_set = low_wrap; // R4
   assign hw_set = {hi_set, lo_set, 6'h00}; // R1 R4
   assign byte_wr_ctrl = sfr_wr & ctrl_sel;
   // Byte write wins over a same-cycle bit write
   assign bit_wr_ctrl = sfr_bit_wr & ctrl_sel & ~sfr_wr; // R7
   // One slice per control bit; bit 1 has no storage and reads zero
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_ctrl_bit
         if (CTRL_WMASK[gi]) begin : g_rw
            localparam [2:0] BIT_SEL = gi;
            wire bit_hit;
            assign bit_hit = bit_wr_ctrl & (sfr_bit_sel == BIT_SEL);
            // Hardware set beats a same-cycle software clear; never cleared here
            assign nxt_control[gi] = hw_set[gi] | (byte_wr_ctrl ? sfr_wdata[gi] :
               (bit_hit ? sfr_bit_val : timer_control_ff[gi])); // R3
         end else begin : g_ro
            assign nxt_control[gi] = 1'b0; // R7
         end
      end
   endgenerate
   always @(posedge clk) begin
      if (reset) begin
         timer_control_ff <= `TMR_CTRL_RESET; // R10
         reload_low_byte_ff <= 8'h00;
         reload_high_byte_ff <= 8'h00;
         comp_prev_ff <= 1'b0;
      end else begin
         timer_control_ff <= nxt_control;
         comp_prev_ff <= comparator_out;
         if (capture) begin
            reload_low_byte_ff <= count_low_byte; // R6
            reload_high_byte_ff <= count_high_byte; // R6
         end else if (sfr_wr) begin
            if (sfr_addr == `TMR_RLL_ADDR) begin
               reload_low_byte_ff <= sfr_wdata;
            end
            if (sfr_addr == `TMR_RLH_ADDR) begin
               reload_high_byte_ff <= sfr_wdata;
            end
         end
      end
   end
   always @* begin
      case (sfr_addr)
         `TMR_CTRL_ADDR: sfr_rdata = timer_control_ff;
         `TMR_RLL_ADDR: sfr_rdata = reload_low_byte_ff;
         `TMR_RLH_ADDR: sfr_rdata = reload_high_byte_ff;
         `TMR_CNTL_ADDR: sfr_rdata = count_low_byte;
         `TMR_CNTH_ADDR: sfr_rdata = count_high_byte;
         default: sfr_rdata = 8'h00;
      endcase
   end
   // Level request while enabled and the high flag, or the low flag with bit 5 set, is pending
   assign timer_irq = timer_irq_enable & (timer_control_ff[`TMR_BIT_HOVF] |
      (timer_control_ff[`TMR_BIT_LIRQ] & timer_control_ff[`TMR_BIT_LOVF])); // R2 R5
endmodule // timer_two
`default_nettype wire

// ### rtl/timer_two_defines.vh
// Constants for the 16-bit / dual 8-bit auto-reload timer and its control register.
// Assumes an 8-bit special function register bus with single-bit writes.
// Summary of operation
// R1: High byte wrap sets high overflow flag.
// R2: High flag set raises timer interrupt.
// R3: Flags cleared only by software writes.
// R4: Low byte wrap sets low overflow flag.
// R5: Bit 5 lets low overflow interrupt too.
// R6: Comparator rising edge captures count into reload.
// R7: Control register at 0xc8, all pages, bit-addressable.
// R8: Capture needs capture enable, split off; sets flag.
// R9: Split mode gives two 8-bit auto-reload counters.
// R10: Control register resets to all zeros.
`ifndef TIMER_TWO_DEFINES_VH
`define TIMER_TWO_DEFINES_VH
`define TMR_CTRL_ADDR 8'hc8
`define TMR_RLL_ADDR 8'hca
`define TMR_RLH_ADDR 8'hcb
`define TMR_CNTL_ADDR 8'hcc
`define TMR_CNTH_ADDR 8'hcd
`define TMR_CTRL_RESET 8'h00
`define TMR_BIT_HOVF 7
`define TMR_BIT_LOVF 6
`define TMR_BIT_LIRQ 5
`define TMR_BIT_CAPEN 4
`define TMR_BIT_SPLIT 3
`define TMR_BIT_RUN 2
`define TMR_BIT_UNUSED 1
`define TMR_BIT_XCLK 0
`define TMR_CTRL_WMASK 8'hfd
`endif

// ### tb/timer_two_asserts.sv
// Port checker for timer_two control flags.
// Assumes it is bound into timer_two and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module timer_two_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic comparator_out,
   input wire logic timer_irq,
   input wire logic split_mode_select
);
   wire at_c = sfr_addr == 8'hc8;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_RST_IRQ: assert property ($past(reset) |-> !timer_irq) else $error("irq after reset");
   AST_IRQ_OFF: assert property (!timer_irq_enable |-> !timer_irq) else $error("irq ungated");
   AST_HI_IRQ: assert property (timer_irq_enable && at_c && sfr_rdata[7] |-> timer_irq) else $error("no irq");
   AST_LO_IRQ: assert property (timer_irq_enable && at_c && sfr_rdata[6:5] == 2'b11 |-> timer_irq)
      else $error("no low irq");
   AST_STICKY: assert property (at_c && !sfr_wr && !sfr_bit_wr && sfr_rdata[7] ##1 at_c |-> sfr_rdata[7])
      else $error("flag lost");
   AST_BYTE_WR: assert property (sfr_wr && at_c ##1 at_c |-> (sfr_rdata & 8'h3d) == ($past(sfr_wdata) & 8'h3d))
      else $error("byte write");
   AST_BIT_WR: assert property (sfr_bit_wr && !sfr_wr && at_c && sfr_bit_sel == 3'h3 |=>
      split_mode_select == $past(sfr_bit_val)) else $error("bit write");
   AST_BIT1: assert property (at_c |-> !sfr_rdata[1]) else $error("bit 1 set");
   AST_CAPT: assert property (at_c && sfr_rdata[4:3] == 2'b10 && $rose(comparator_out) |=> !at_c || sfr_rdata[7])
      else $error("capture flag");
endmodule // timer_two_chk
bind timer_two timer_two_chk timer_two_chk_i (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel,
   .sfr_bit_val, .sfr_rdata, .timer_irq_enable, .comparator_out, .timer_irq, .split_mode_select);
`default_nettype wire

// ### tb/timer_two_bench.sv
// Bench for timer_two: reset, overflows, capture, bit access.
// Assumes timer_two_chk is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module timer_two_bench;
   logic clk = 0, reset = 1, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, ien = 0, th = 0, tl = 0, cmp = 0;
   logic [7:0] sfr_addr = 8'hc8, sfr_wdata = 8'h00;
   logic [2:0] sfr_bit_sel = 3'h0;
   wire [7:0] sfr_rdata;
   wire timer_irq, split_mode_select, external_clock_select;
   int num_errors = 0, checks_done = 0;
   always #2 clk = ~clk;
   timer_two timer_two_i (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val,
      .sfr_rdata, .timer_irq_enable(ien), .tick_high(th), .tick_low(tl), .comparator_out(cmp), .timer_irq,
      .split_mode_select, .external_clock_select);
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) begin sfr_addr <= a; sfr_wdata <= d; sfr_wr <= 1; end
      @(posedge clk) sfr_wr <= 0;
   endtask
   task automatic bw(input logic [2:0] s, input logic v);
      @(posedge clk) begin sfr_bit_sel <= s; sfr_bit_val <= v; sfr_bit_wr <= 1; end
      @(posedge clk) sfr_bit_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) sfr_addr <= a;
      #1 chk("rdata", sfr_rdata, exp);
   endtask
   task automatic t_low;
      rd(8'hc8, 8'h00);
      wr(8'hc8, 8'h24);
      @(posedge clk) begin tl <= 1; ien <= 1; end
      repeat (256) @(posedge clk);
      tl <= 0;
      rd(8'hc8, 8'h64);
      chk("irq", timer_irq, 8'h01);
      $display("low wrap test done");
   endtask
   task automatic t_cap;
      wr(8'hc8, 8'h10);
      #1 chk("irq", timer_irq, 8'h00);
      @(posedge clk) cmp <= 1;
      rd(8'hc8, 8'h90);
      chk("irq", timer_irq, 8'h01);
      rd(8'hca, 8'h00);
      rd(8'hcb, 8'h01);
      cmp <= 0;
      $display("capture test done");
   endtask
   task automatic t_split;
      wr(8'hc8, 8'h0c);
      @(posedge clk) th <= 1;
      repeat (300) @(posedge clk);
      th <= 0;
      rd(8'hc8, 8'h8c);
      rd(8'hcd, 8'h2e);
      wr(8'hca, 8'hf0);
      @(posedge clk) tl <= 1;
      repeat (261) @(posedge clk);
      tl <= 0;
      rd(8'hcc, 8'hf5);
      rd(8'hc8, 8'hcc);
      bw(3'h7, 1'b0);
      bw(3'h6, 1'b0);
      bw(3'h1, 1'b1);
      bw(3'h3, 1'b0);
      rd(8'hc8, 8'h04);
      wr(8'hc8, 8'hff);
      rd(8'hc8, 8'hfd);
      chk("split", split_mode_select, 8'h01);
      chk("xclk", external_clock_select, 8'h01);
      $display("split test done");
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset <= 0;
      t_low;
      t_cap;
      t_split;
      end_sim;
   end
endmodule // timer_two_bench
`default_nettype wire
